// >>> sram_port_pkg.sv
// Shared constants, types and helpers for the pipelined burst SRAM port
package sram_port_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_BITS = 8;
  localparam int WORD_W = DATA_W + LANES;
  localparam int BURST_W = 2;
  localparam int DEPTH = 1 << ADDR_W;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [ADDR_W-BURST_W-1:0] upper_t;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [LANES-1:0] lanes_t;
  typedef logic [BURST_W-1:0] burst_t;

  localparam burst_t BURST_FIRST = 2'h0;
  localparam burst_t BURST_ONE = 2'h1;
  localparam word_t WORD_RESET = 36'h0;
  localparam addr_t ADDR_RESET = 18'h0;
  localparam lanes_t LANES_OFF = 4'hF;

  typedef enum {CYC_IDLE, CYC_READ, CYC_WRITE} cyc_e;

  // Low address bits for a burst step, interleaved or linear
  function automatic burst_t burst_low(burst_t seed, burst_t step, logic interleave);
    burst_low = interleave ? (seed ^ step) : burst_t'(seed + step);
  endfunction

  // Bit mask of the lanes written; each lane is one byte plus its parity bit
  function automatic word_t lane_mask(lanes_t write_n);
    word_t m;
    m = WORD_RESET;
    for (int i = 0; i < LANES; i++) begin
      if (!write_n[i]) begin
        m[i*LANE_BITS +: LANE_BITS] = '1;
        m[DATA_W + i] = 1'b1;
      end
    end
    lane_mask = m;
  endfunction

  function automatic word_t merge_word(word_t old_w, word_t new_w, word_t mask);
    merge_word = (old_w & ~mask) | (new_w & mask);
  endfunction

endpackage

// >>> sram_link.sv
// Pin bundle between the memory end and the controller end
`timescale 1ns/10ps
interface sram_link;
  import sram_port_pkg::*;

  logic clock_enable_n;
  logic burst_step_or_load;
  logic chip_select_primary_n;
  logic chip_select_secondary;
  logic chip_select_tertiary_n;
  logic write_n;
  lanes_t byte_lane_write_n;
  addr_t address;
  logic output_enable_n;
  word_t mem_data;
  logic mem_data_oe;
  word_t ctl_data;
  logic ctl_data_oe;
  word_t data_lines;

  // Shared bus level; the parties never drive together
  assign data_lines = mem_data_oe ? mem_data : (ctl_data_oe ? ctl_data : WORD_RESET);

  modport memory_port (
    input clock_enable_n, burst_step_or_load, chip_select_primary_n,
    input chip_select_secondary, chip_select_tertiary_n, write_n,
    input byte_lane_write_n, address, output_enable_n, data_lines,
    output mem_data, mem_data_oe
  );

  modport controller_port (
    output clock_enable_n, burst_step_or_load, chip_select_primary_n,
    output chip_select_secondary, chip_select_tertiary_n, write_n,
    output byte_lane_write_n, address, output_enable_n,
    output ctl_data, ctl_data_oe,
    input data_lines
  );
endinterface

// >>> burst_counter.sv
// Two-bit burst counter with interleaved or linear order
`timescale 1ns/10ps
module burst_counter
  import sram_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic suspend_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire sram_port_pkg::burst_t seed_i,
  input wire logic interleave_i,
  output sram_port_pkg::burst_t next_low_o
);
  import sram_port_pkg::*;

  burst_t seed;
  burst_t count;

  // Address of the next step, from held seed and count
  assign next_low_o = burst_low(seed, burst_t'(count + BURST_ONE), interleave_i);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seed <= BURST_FIRST;
      count <= BURST_FIRST;
    end else if (!suspend_i) begin
      if (load_i) begin
        seed <= seed_i;
        count <= BURST_FIRST;
      end else if (step_i) begin
        count <= burst_t'(count + BURST_ONE);
      end
    end
  end
endmodule

// >>> sram_mem_end.sv
// Memory end: pipelined burst SRAM with no read/write turnaround
`timescale 1ns/10ps
module sram_mem_end
  import sram_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic order_select_i,
  sram_link.memory_port link
);
  import sram_port_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Array and pipeline state

  word_t mem [DEPTH];

  cyc_e burst_type;
  upper_t upper_addr;
  cyc_e s1_type;
  addr_t s1_addr;
  lanes_t s1_lanes;
  cyc_e s2_type;
  addr_t s2_addr;
  lanes_t s2_lanes;
  word_t read_word;
  logic drive;

  ////////////////////////////////////////////////////////////////////
  // Input decode

  logic enabled;
  logic selected;
  logic load;
  burst_t next_low;
  addr_t next_addr;
  cyc_e next_type;
  word_t s2_merged;
  word_t next_read;
  logic s1_read;
  logic s2_write;

  assign enabled = !link.clock_enable_n;

  // Depth expansion needs every select active
  assign selected = !link.chip_select_primary_n
                    && link.chip_select_secondary
                    && !link.chip_select_tertiary_n;

  assign load = !link.burst_step_or_load;

  ////////////////////////////////////////////////////////////////////
  // Burst counter

  // Upper address bits stay in the burst context; only the low two move
  burst_counter burst_counter_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .suspend_i(!enabled),
    .load_i(load),
    .step_i(link.burst_step_or_load),
    .seed_i(link.address[BURST_W-1:0]),
    .interleave_i(order_select_i),
    .next_low_o(next_low)
  );

  // Load takes the pins; a step reuses the held upper bits
  always_comb begin
    if (load) begin
      next_addr = link.address;
    end else begin
      next_addr = {upper_addr, next_low};
    end
  end

  // Cycle type: chosen on load, carried through the burst
  always_comb begin
    if (!load) begin
      next_type = burst_type;
    end else if (!selected) begin
      next_type = CYC_IDLE;
    end else if (link.write_n) begin
      next_type = CYC_READ;
    end else begin
      next_type = CYC_WRITE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Burst context

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_type <= CYC_IDLE;
      upper_addr <= ADDR_RESET[ADDR_W-1:BURST_W];
    end else if (enabled && load) begin
      burst_type <= next_type;
      upper_addr <= link.address[ADDR_W-1:BURST_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address and control pipeline

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_type <= CYC_IDLE;
      s1_addr <= ADDR_RESET;
      s1_lanes <= LANES_OFF;
    end else if (enabled) begin
      s1_type <= next_type;
      s1_addr <= next_addr;
      s1_lanes <= link.byte_lane_write_n;
    end
  end

  // Second stage lines up with the data slot on the shared bus
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s2_type <= CYC_IDLE;
      s2_addr <= ADDR_RESET;
      s2_lanes <= LANES_OFF;
    end else if (enabled) begin
      s2_type <= s1_type;
      s2_addr <= s1_addr;
      s2_lanes <= s1_lanes;
    end
  end

  // Slot decode shared by the forwarding and read paths
  assign s1_read = (s1_type == CYC_READ);
  assign s2_write = (s2_type == CYC_WRITE);

  ////////////////////////////////////////////////////////////////////
  // Array write, late write with data two cycles after address

  assign s2_merged = merge_word(mem[s2_addr], link.data_lines, lane_mask(s2_lanes));

  // Self-timed from the controller's view: one edge commits the word
  always_ff @(posedge ref_clk_i) begin
    if (!rst_i && enabled) begin
      case (s2_type)
        CYC_WRITE: begin
          mem[s2_addr] <= s2_merged;
        end
        CYC_READ, CYC_IDLE: begin
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path

  // A read right behind a write to the same word must see the new data,
  // since both land on the same edge
  always_comb begin
    if (s2_write && s2_addr == s1_addr) begin
      next_read = s2_merged;
    end else begin
      next_read = mem[s1_addr];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_word <= WORD_RESET;
    end else if (enabled && s1_read) begin
      read_word <= next_read;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive <= 1'b0;
    end else if (enabled) begin
      drive <= s1_read;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus drive

  assign link.mem_data = read_word;
  // Output enable acts without the clock
  assign link.mem_data_oe = drive && !link.output_enable_n;

endmodule

// >>> sram_ctl_end.sv
// Controller end: issues commands and moves data over the shared bus
`timescale 1ns/10ps
module sram_ctl_end
  import sram_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_step_i,
  input wire logic cmd_write_i,
  input wire sram_port_pkg::addr_t cmd_addr_i,
  input wire sram_port_pkg::lanes_t cmd_lanes_i,
  input wire sram_port_pkg::word_t cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rd_valid_o,
  output sram_port_pkg::word_t rd_data_o,
  sram_link.controller_port link
);
  import sram_port_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Pin registers

  logic cke_n;
  logic step;
  logic sel;
  logic wr_n;
  lanes_t lanes_n;
  addr_t addr;
  word_t pin_wdata;
  cyc_e burst_type;
  cyc_e pin_type;
  cyc_e p1_type;
  word_t p1_data;
  cyc_e p2_type;
  word_t p2_data;

  // Commands offered during a hold are lost at the memory
  assign cmd_ready_o = !hold_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cke_n <= 1'b1;
      step <= 1'b0;
      sel <= 1'b0;
      wr_n <= 1'b1;
      lanes_n <= LANES_OFF;
      addr <= ADDR_RESET;
      pin_wdata <= WORD_RESET;
    end else begin
      cke_n <= hold_i;
      step <= cmd_valid_i && cmd_step_i;
      sel <= cmd_valid_i && !cmd_step_i;
      wr_n <= !cmd_write_i;
      lanes_n <= ~cmd_lanes_i;
      addr <= cmd_addr_i;
      pin_wdata <= cmd_wdata_i;
    end
  end

  assign link.clock_enable_n = cke_n;
  assign link.burst_step_or_load = step;
  assign link.chip_select_primary_n = !sel;
  assign link.chip_select_secondary = sel;
  assign link.chip_select_tertiary_n = !sel;
  assign link.write_n = wr_n;
  assign link.byte_lane_write_n = lanes_n;
  assign link.address = addr;

  ////////////////////////////////////////////////////////////////////
  // Tracking the memory pipeline

  always_comb begin
    if (step) begin
      pin_type = burst_type;
    end else if (!sel) begin
      pin_type = CYC_IDLE;
    end else if (wr_n) begin
      pin_type = CYC_READ;
    end else begin
      pin_type = CYC_WRITE;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_type <= CYC_IDLE;
      p1_type <= CYC_IDLE;
      p1_data <= WORD_RESET;
      p2_type <= CYC_IDLE;
      p2_data <= WORD_RESET;
    end else if (!cke_n) begin
      if (!step) begin
        burst_type <= pin_type;
      end
      p1_type <= pin_type;
      p1_data <= pin_wdata;
      p2_type <= p1_type;
      p2_data <= p1_data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= WORD_RESET;
    end else begin
      rd_valid_o <= !cke_n && p2_type == CYC_READ;
      if (!cke_n && p2_type == CYC_READ) begin
        rd_data_o <= link.data_lines;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus drive: write data only, read output enabled only when expected

  assign link.ctl_data = p2_data;
  assign link.ctl_data_oe = (p2_type == CYC_WRITE);
  assign link.output_enable_n = (p2_type != CYC_READ);

endmodule

// >>> sram_link_sva.sv
// Assertions on the pins between the memory end and the controller end
`timescale 1ns/10ps
module sram_link_sva
  import sram_port_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clock_enable_n,
  input wire logic burst_step_or_load,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_secondary,
  input wire logic chip_select_tertiary_n,
  input wire logic write_n,
  input wire logic output_enable_n,
  input wire sram_port_pkg::word_t mem_data,
  input wire logic mem_data_oe,
  input wire logic ctl_data_oe
);
  import sram_port_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic sel = !chip_select_primary_n && chip_select_secondary && !chip_select_tertiary_n;
  wire logic ld = !clock_enable_n && !burst_step_or_load;
  wire logic rd_ld = ld && sel && write_n;
  wire logic wr_ld = ld && sel && !write_n;
  ////////////////////////////////////////////////////////////////////////////////
  property p_no_clash;
    !(mem_data_oe && ctl_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data lines");
  property p_oe_gate;
    output_enable_n |-> !mem_data_oe;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("read drive without output enable");
  property p_desel;
    ld && !sel ##1 !clock_enable_n |=> !mem_data_oe && !ctl_data_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("bus driven in a deselect slot");
  property p_rd_slot;
    rd_ld ##1 !clock_enable_n |=> mem_data_oe && !ctl_data_oe;
  endproperty
  a_rd_slot: assert property (p_rd_slot)
    else $error("read data missing two cycles after load");
  property p_wr_slot;
    wr_ld ##1 !clock_enable_n |=> ctl_data_oe && !mem_data_oe;
  endproperty
  a_wr_slot: assert property (p_wr_slot)
    else $error("write data missing two cycles after load");
  // Bus drive must freeze on a held edge, so the data slot simply stretches
  property p_hold_mem;
    clock_enable_n |=> $stable(mem_data_oe) && $stable(mem_data);
  endproperty
  a_hold_mem: assert property (p_hold_mem)
    else $error("memory moved on a held edge");
  property p_hold_ctl;
    clock_enable_n |=> $stable(ctl_data_oe) && $stable(output_enable_n);
  endproperty
  a_hold_ctl: assert property (p_hold_ctl)
    else $error("controller slot moved on a held edge");
  property p_turn;
    rd_ld ##1 wr_ld ##1 !clock_enable_n [*2] |-> ctl_data_oe && $past(mem_data_oe);
  endproperty
  a_turn: assert property (p_turn)
    else $error("gap between read and write slots");
  c_read: cover property (rd_ld ##1 !clock_enable_n ##1 mem_data_oe);
  c_write: cover property (wr_ld ##1 !clock_enable_n ##1 ctl_data_oe);
  c_hold: cover property (clock_enable_n ##1 !clock_enable_n);
endmodule

// >>> tb_pipelined_burst_sram_port.sv
// Testbench joining the memory end and the controller end
`timescale 1ns/10ps
module tb_pipelined_burst_sram_port;
  import sram_port_pkg::*;
  logic ref_clk_i, rst_i, order_sel, hold, valid, step, wr, ready, rd_valid, lwr;
  addr_t addr, la;
  lanes_t lanes;
  word_t wdata, rd_data;
  word_t model [int];
  word_t expq [$];
  int err_count, cmp_count, k;
  sram_link sram_link_i ();
  sram_mem_end sram_mem_end_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .order_select_i(order_sel),
    .link(sram_link_i.memory_port)
  );
  sram_ctl_end sram_ctl_end_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .hold_i(hold),
    .cmd_valid_i(valid),
    .cmd_step_i(step),
    .cmd_write_i(wr),
    .cmd_addr_i(addr),
    .cmd_lanes_i(lanes),
    .cmd_wdata_i(wdata),
    .cmd_ready_o(ready),
    .rd_valid_o(rd_valid),
    .rd_data_o(rd_data),
    .link(sram_link_i.controller_port)
  );
  sram_link_sva sram_link_sva_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clock_enable_n(sram_link_i.clock_enable_n),
    .burst_step_or_load(sram_link_i.burst_step_or_load),
    .chip_select_primary_n(sram_link_i.chip_select_primary_n),
    .chip_select_secondary(sram_link_i.chip_select_secondary),
    .chip_select_tertiary_n(sram_link_i.chip_select_tertiary_n),
    .write_n(sram_link_i.write_n),
    .output_enable_n(sram_link_i.output_enable_n),
    .mem_data(sram_link_i.mem_data),
    .mem_data_oe(sram_link_i.mem_data_oe),
    .ctl_data_oe(sram_link_i.ctl_data_oe)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(string name, word_t got, word_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rst(bit o);
    rst_i = 1'b1;
    order_sel = o;
    valid = 1'b0;
    hold = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
  endtask
  // Model tracks burst address and lane merge; steps reuse the last load type
  task automatic cmd(bit s, bit w, addr_t a, lanes_t l, word_t d);
    int ea;
    word_t m;
    @(negedge ref_clk_i);
    hold = 1'b0;
    valid = 1'b1;
    step = s;
    wr = w;
    addr = a;
    lanes = l;
    wdata = d;
    if (!s) begin
      la = a;
      lwr = w;
      k = 0;
    end else
      k++;
    ea = {la[17:2], 2'(order_sel ? la[1:0] ^ k : la[1:0] + k)};
    if (lwr) begin
      m = model[ea];
      for (int i = 0; i < 4; i++) begin
        if (l[i]) begin
          m[i*8 +: 8] = d[i*8 +: 8];
          m[32+i] = d[32+i];
        end
      end
      model[ea] = m;
    end else
      expq.push_back(model[ea]);
  endtask
  task automatic burst(bit w, addr_t a, word_t d0);
    for (int i = 0; i < 4; i++)
      cmd(i != 0, w, a, 4'hF, d0 + word_t'(i) * 36'h1_1111_1111);
  endtask
  task automatic pause(bit h, int n);
    repeat (n) begin
      @(negedge ref_clk_i);
      valid = 1'b0;
      hold = h;
      #1 chk("ready", word_t'(ready), word_t'(!h));
    end
  endtask
  task automatic done(string name);
    pause(0, 10);
    chk("pending", word_t'(expq.size()), '0);
    $display("test %s done", name);
  endtask
  always @(negedge ref_clk_i)
    if (rd_valid === 1'b1)
      chk("rd_data", rd_data, expq.size() ? expq.pop_front() : 'x);
  initial begin
    #(5000 * 100);
    err_count++;
    results();
  end
  initial begin
    step = 1'b0;
    wr = 1'b0;
    addr = '0;
    lanes = '0;
    wdata = '0;
    rst(1'b0);
    burst(1'b1, 18'h00006, 36'h8_0102_0304);
    burst(1'b0, 18'h00006, '0);
    done("linear");
    // Partial lanes leave the other bytes and their parity alone
    cmd(0, 1, 18'h00005, 4'h5, 36'hF_FFFF_FFFF);
    cmd(0, 0, 18'h00005, 4'h0, '0);
    cmd(0, 1, 18'h00007, 4'hA, 36'h0_0000_0000);
    cmd(0, 0, 18'h00007, 4'h0, '0);
    done("lanes");
    cmd(0, 0, 18'h00004, 4'h0, '0);
    pause(1, 2);
    cmd(1, 0, 18'h00004, 4'h0, '0);
    pause(1, 1);
    cmd(1, 0, 18'h00004, 4'h0, '0);
    pause(0, 1);
    done("hold");
    // Mid-run reset is raised on a falling edge like every other input
    @(negedge ref_clk_i);
    rst(1'b1);
    burst(1'b1, 18'h3FFFD, 36'h5_A5A5_0F0F);
    burst(1'b0, 18'h3FFFE, '0);
    done("interleave");
    results();
  end
endmodule
